// ==== timer_pair_pkg.sv ====
// Purpose: constants and types for the cascadable timer pair block
// Assumes: apb register access, 32-bit words, low byte used
// Notes:   offsets are byte addresses
package timer_pair_pkg;
  localparam logic [7:0] ADDR_RUN     = 8'h00;
  localparam logic [7:0] ADDR_CLKSEL  = 8'h04;
  localparam logic [7:0] ADDR_MODE    = 8'h08;
  localparam logic [7:0] ADDR_FFCTL   = 8'h0c;
  localparam logic [7:0] ADDR_CMP_LO  = 8'h10;
  localparam logic [7:0] ADDR_CMP_HI  = 8'h14;
  localparam logic [7:0] ADDR_CMP2_LO = 8'h18;
  localparam logic [7:0] ADDR_CMP2_HI = 8'h1c;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;
  localparam logic [7:0] ADDR_CNT     = 8'h24;
  localparam logic [7:0] ADDR_PIN     = 8'h28;

  // pair mode codes
  localparam logic [1:0] MODE_8BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_PPG   = 2'h2;
  localparam logic [1:0] MODE_PWM   = 2'h3;
  // flip-flop commands
  localparam logic [1:0] FF_CLEAR   = 2'h0;
  localparam logic [1:0] FF_SET     = 2'h1;
  localparam logic [1:0] FF_INVERT  = 2'h2;
  // clock select codes
  localparam logic [1:0] CLK_MATCH  = 2'h0;
  localparam logic [1:0] CLK_T1     = 2'h1;
  localparam logic [1:0] CLK_T16    = 2'h2;
  localparam logic [1:0] CLK_T256   = 2'h3;
  // prescaler taps: bit index of free-running divider
  localparam int PRE_W    = 9;
  localparam int TAP_T1   = 0;
  localparam int TAP_T16  = 4;
  localparam int TAP_T256 = 8;
  localparam logic [8:0] PRE_DIV = 9'h002;  // system clocks per prescaler step
  localparam logic [7:0] PWM_TOP6 = 8'h3f;
  localparam logic [7:0] PWM_TOP7 = 8'h7f;
  localparam logic [7:0] PWM_TOP8 = 8'hff;
  // ffctl bit positions
  localparam int FF_CMD_LSB = 0;
  localparam int FF_IE_BIT  = 2;
  localparam int FF_IS_BIT  = 3;
  localparam int FF_CMD_NOP = 3;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic       irq_lo;
    logic       irq_hi;
  } pair_state_t;
endpackage

// ==== timer_pair.sv ====
// Purpose: two cascadable 8-bit timer pairs, toggle flip-flop, ppg and pwm output
// Assumes: single 200 MHz clock, apb slave, zero-wait answers
// Notes:   second pair cascades only and has no output pin
// Functional notes
// - command 1,0 inverts flip-flop immediately
// - command 0,0 clears, 0,1 sets flip-flop
// - mode 0,1 cascades pair into 16 bits
// - cascaded upper counts lower overflow only
// - second pair cascades alike, no pin
// - lower compare low byte, upper high byte
// - lower compare write holds off 16-bit compare
// - cascaded lower match irqs, keeps counting
// - double match clears both, irq, toggles
// - 8-bit chained lower clears on match
// - ppg toggles on upper equal either compare
// - pulse polarity from preset flip-flop level
// - pwm on first upper timer, lower independent
// - pwm toggles on match and 2^n-1 overflow
// - pwm raises upper irq on each match
// - toggle enable bit gates compare inversion
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module timer_pair #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // timer events and pin
  output logic      [3:0]  match_irq_o,
  output logic             flipflop_output_pin_o,
  output logic             shared_port_pin_o
);
  timer_pair_pkg::apb_req_t req;
  assign req = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};
  wire wr = req.psel && req.penable && req.pwrite;
  wire known = req.paddr inside {timer_pair_pkg::ADDR_RUN, timer_pair_pkg::ADDR_CLKSEL,
    timer_pair_pkg::ADDR_MODE, timer_pair_pkg::ADDR_FFCTL, timer_pair_pkg::ADDR_CMP_LO,
    timer_pair_pkg::ADDR_CMP_HI, timer_pair_pkg::ADDR_CMP2_LO, timer_pair_pkg::ADDR_CMP2_HI,
    timer_pair_pkg::ADDR_STATUS, timer_pair_pkg::ADDR_CNT, timer_pair_pkg::ADDR_PIN};
  assign pready_o  = 1'b1;
  assign pslverr_o = req.psel && req.penable && !known;

  // software registers
  logic [3:0]  run_control_reg, next_run;
  logic [7:0]  clock_select_reg, next_clksel;   // [1:0] lo0 [3:2] hi0 [5:4] lo1 [7:6] hi1
  logic [5:0]  timer_mode_reg, next_mode;       // [1:0] pair0 [3:2] pwm [5:4] pair1
  logic [1:0]  ff_ctl, next_ff_ctl;             // ie, is
  logic [7:0]  compare_low, compare_high, cmp2_lo, cmp2_hi;
  logic [7:0]  next_cmp_lo, next_cmp_hi, next_cmp2_lo, next_cmp2_hi;
  logic [1:0]  arm16, next_arm16;
  logic        pin_sel, next_pin_sel;
  logic [8:0]  pre_div, next_pre_div;
  logic [timer_pair_pkg::PRE_W-1:0] pre, next_pre;
  logic [timer_pair_pkg::PRE_W-1:0] pre_q;
  logic [CNT_W-1:0] counter_low, counter_high, cnt2_lo, cnt2_hi;
  logic [CNT_W-1:0] next_c0, next_c1, next_c2, next_c3;
  logic        toggle_flipflop, next_tff;
  logic [3:0]  next_irq;
  logic [31:0] next_rdata;

  // rising edge of a prescaler tap
  function automatic logic tick(input logic [1:0] sel, input logic [8:0] now,
                                input logic [8:0] was);
    int b;
    b = (sel == timer_pair_pkg::CLK_T16) ? timer_pair_pkg::TAP_T16 :
        (sel == timer_pair_pkg::CLK_T256) ? timer_pair_pkg::TAP_T256 :
        timer_pair_pkg::TAP_T1;
    return now[b] && !was[b];
  endfunction

  function automatic logic [7:0] pwm_top(input logic [1:0] sel);
    return (sel == 2'h1) ? timer_pair_pkg::PWM_TOP6 :
           (sel == 2'h2) ? timer_pair_pkg::PWM_TOP7 : timer_pair_pkg::PWM_TOP8;
  endfunction

  // match on the value the next tick reaches: compare n gives n ticks, 0 a full wrap
  function automatic logic hit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp);
    logic [CNT_W-1:0] nxt;
    nxt = cnt + 1'b1;
    return nxt == cmp;
  endfunction

  function automatic logic hit2(input logic [CNT_W-1:0] hi, input logic [CNT_W-1:0] lo,
                                input logic [CNT_W-1:0] chi, input logic [CNT_W-1:0] clo);
    logic [2*CNT_W-1:0] nxt;
    nxt = {hi, lo} + 1'b1;
    return nxt == {chi, clo};
  endfunction

  // register writes
  always_comb begin
    next_run     = run_control_reg;
    next_clksel  = clock_select_reg;
    next_mode    = timer_mode_reg;
    next_ff_ctl  = ff_ctl;
    next_cmp_lo  = compare_low;
    next_cmp_hi  = compare_high;
    next_cmp2_lo = cmp2_lo;
    next_cmp2_hi = cmp2_hi;
    next_arm16   = arm16;
    next_pin_sel = pin_sel;
    if (wr) begin
      unique case (req.paddr)
        timer_pair_pkg::ADDR_RUN:    next_run    = req.pwdata[3:0];
        timer_pair_pkg::ADDR_CLKSEL: next_clksel = req.pwdata[7:0];
        timer_pair_pkg::ADDR_MODE:   next_mode   = req.pwdata[5:0];
        timer_pair_pkg::ADDR_FFCTL:  next_ff_ctl = {req.pwdata[timer_pair_pkg::FF_IS_BIT],
                                                    req.pwdata[timer_pair_pkg::FF_IE_BIT]};
        timer_pair_pkg::ADDR_CMP_LO: begin
          next_cmp_lo = req.pwdata[7:0];
          next_arm16[0] = 1'b0;
        end
        timer_pair_pkg::ADDR_CMP_HI: begin
          next_cmp_hi = req.pwdata[7:0];
          next_arm16[0] = 1'b1;
        end
        timer_pair_pkg::ADDR_CMP2_LO: begin
          next_cmp2_lo = req.pwdata[7:0];
          next_arm16[1] = 1'b0;
        end
        timer_pair_pkg::ADDR_CMP2_HI: begin
          next_cmp2_hi = req.pwdata[7:0];
          next_arm16[1] = 1'b1;
        end
        timer_pair_pkg::ADDR_PIN: next_pin_sel = req.pwdata[0];
        default: ;
      endcase
    end
  end

  // prescaler, free running, one step every PRE_DIV clocks
  always_comb begin
    next_pre_div = pre_div + 9'h001;
    next_pre     = pre;
    if (pre_div == timer_pair_pkg::PRE_DIV - 9'h001) begin
      next_pre_div = 9'h000;
      next_pre     = pre + 9'h001;
    end
  end

  // counting, matches, flip-flop
  always_comb begin
    logic t0, t1, t2, t3, eq0, eq2, tog, top_hit;
    logic [1:0] cmd;
    // lower timers always use their own clock select
    t0 = run_control_reg[0] && tick(clock_select_reg[1:0], pre, pre_q);
    t1 = 1'b0;
    t2 = run_control_reg[2] && tick(clock_select_reg[5:4], pre, pre_q);
    t3 = 1'b0;
    eq0 = t0 && hit(counter_low, compare_low);
    eq2 = t2 && hit(cnt2_lo, cmp2_lo);
    tog = 1'b0;
    top_hit = 1'b0;
    cmd = req.pwdata[timer_pair_pkg::FF_CMD_LSB +: 2];
    next_c0 = counter_low;
    next_c1 = counter_high;
    next_c2 = cnt2_lo;
    next_c3 = cnt2_hi;
    next_irq = 4'h0;
    next_tff = toggle_flipflop;
    // ---- pair 0 ----
    unique case (timer_mode_reg[1:0])
      timer_pair_pkg::MODE_16BIT: begin
        t1 = run_control_reg[1] && t0 && counter_low == '1;
        if (t0) next_c0 = counter_low + 1'b1;
        if (t1) next_c1 = counter_high + 1'b1;
        next_irq[0] = eq0;
        if (t0 && arm16[0] && hit2(counter_high, counter_low, compare_high, compare_low)) begin
          next_c0 = '0;
          next_c1 = '0;
          next_irq[1] = 1'b1;
          tog = ff_ctl[1];
        end
      end
      timer_pair_pkg::MODE_PPG: begin
        // lower keeps counting; only the count register read sees it
        t1 = run_control_reg[1] && tick(clock_select_reg[3:2], pre, pre_q);
        if (t0) next_c0 = counter_low + 1'b1;
        if (t1) begin
          next_c1 = hit(counter_high, compare_high) ? '0 : counter_high + 1'b1;
          next_irq[0] = hit(counter_high, compare_low);
          next_irq[1] = hit(counter_high, compare_high);
          tog = next_irq[0] || next_irq[1];
        end
      end
      timer_pair_pkg::MODE_PWM: begin
        // lower stays a plain 8-bit interval timer
        if (eq0) next_c0 = '0;
        else if (t0) next_c0 = counter_low + 1'b1;
        next_irq[0] = eq0;
        t1 = run_control_reg[1] && tick(clock_select_reg[3:2], pre, pre_q);
        if (t1) begin
          top_hit = hit(counter_high, pwm_top(timer_mode_reg[3:2]));
          next_c1 = top_hit ? '0 : counter_high + 1'b1;
          next_irq[1] = hit(counter_high, compare_high);
          tog = top_hit || next_irq[1];
        end
      end
      default: begin
        // plain 8-bit pair, upper may chain on lower match
        if (eq0) next_c0 = '0;
        else if (t0) next_c0 = counter_low + 1'b1;
        next_irq[0] = eq0;
        t1 = run_control_reg[1] && (clock_select_reg[3:2] == timer_pair_pkg::CLK_MATCH ? eq0
             : tick(clock_select_reg[3:2], pre, pre_q));
        next_irq[1] = t1 && hit(counter_high, compare_high);
        if (next_irq[1]) next_c1 = '0;
        else if (t1) next_c1 = counter_high + 1'b1;
        tog = ff_ctl[1] ? next_irq[1] : eq0;
      end
    endcase
    // ---- pair 1, no output pin ----
    if (timer_mode_reg[5:4] == timer_pair_pkg::MODE_16BIT) begin
      t3 = run_control_reg[3] && t2 && cnt2_lo == '1;
      if (t2) next_c2 = cnt2_lo + 1'b1;
      if (t3) next_c3 = cnt2_hi + 1'b1;
      next_irq[2] = eq2;
      if (t2 && arm16[1] && hit2(cnt2_hi, cnt2_lo, cmp2_hi, cmp2_lo)) begin
        next_c2 = '0;
        next_c3 = '0;
        next_irq[3] = 1'b1;
      end
    end else begin
      if (eq2) next_c2 = '0;
      else if (t2) next_c2 = cnt2_lo + 1'b1;
      next_irq[2] = eq2;
      t3 = run_control_reg[3] && (clock_select_reg[7:6] == timer_pair_pkg::CLK_MATCH ? eq2
           : tick(clock_select_reg[7:6], pre, pre_q));
      next_irq[3] = t3 && hit(cnt2_hi, cmp2_hi);
      if (next_irq[3]) next_c3 = '0;
      else if (t3) next_c3 = cnt2_hi + 1'b1;
    end
    // stopped timers clear
    if (!run_control_reg[0]) next_c0 = '0;
    if (!run_control_reg[1]) next_c1 = '0;
    if (!run_control_reg[2]) next_c2 = '0;
    if (!run_control_reg[3]) next_c3 = '0;
    // hardware toggle, gated by enable
    if (tog && ff_ctl[0]) next_tff = !toggle_flipflop;
    // software command wins over compare toggle
    if (wr && req.paddr == timer_pair_pkg::ADDR_FFCTL) begin
      unique case (cmd)
        timer_pair_pkg::FF_CLEAR:  next_tff = 1'b0;
        timer_pair_pkg::FF_SET:    next_tff = 1'b1;
        timer_pair_pkg::FF_INVERT: next_tff = !toggle_flipflop;
        default: ;
      endcase
    end
  end

  // read data; flip-flop and compares read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (req.paddr)
      timer_pair_pkg::ADDR_RUN:    next_rdata = {28'h0, run_control_reg};
      timer_pair_pkg::ADDR_CLKSEL: next_rdata = {24'h0, clock_select_reg};
      timer_pair_pkg::ADDR_MODE:   next_rdata = {26'h0, timer_mode_reg};
      timer_pair_pkg::ADDR_STATUS: next_rdata = {28'h0, match_irq_o};
      timer_pair_pkg::ADDR_CNT:    next_rdata = {counter_high, counter_low, cnt2_hi, cnt2_lo};
      timer_pair_pkg::ADDR_PIN:    next_rdata = {31'h0, pin_sel};
      default:                     next_rdata = 32'h0000_0000;
    endcase
  end
  assign prdata_o = next_rdata;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      run_control_reg  <= 4'h0;
      clock_select_reg <= 8'h00;
      timer_mode_reg   <= 6'h00;
      ff_ctl           <= 2'h0;
      compare_low      <= 8'h00;
      compare_high     <= 8'h00;
      cmp2_lo          <= 8'h00;
      cmp2_hi          <= 8'h00;
      arm16            <= 2'h3;
      pin_sel          <= 1'b0;
      pre_div          <= 9'h000;
      pre              <= 9'h000;
      pre_q            <= 9'h000;
      counter_low      <= 8'h00;
      counter_high     <= 8'h00;
      cnt2_lo          <= 8'h00;
      cnt2_hi          <= 8'h00;
      toggle_flipflop  <= 1'b0;
      match_irq_o      <= 4'h0;
      flipflop_output_pin_o <= 1'b0;
      shared_port_pin_o     <= 1'b0;
    end else begin
      run_control_reg  <= next_run;
      clock_select_reg <= next_clksel;
      timer_mode_reg   <= next_mode;
      ff_ctl           <= next_ff_ctl;
      compare_low      <= next_cmp_lo;
      compare_high     <= next_cmp_hi;
      cmp2_lo          <= next_cmp2_lo;
      cmp2_hi          <= next_cmp2_hi;
      arm16            <= next_arm16;
      pin_sel          <= next_pin_sel;
      pre_div          <= next_pre_div;
      pre              <= next_pre;
      pre_q            <= pre;
      counter_low      <= next_c0;
      counter_high     <= next_c1;
      cnt2_lo          <= next_c2;
      cnt2_hi          <= next_c3;
      toggle_flipflop  <= next_tff;
      match_irq_o      <= next_irq;
      flipflop_output_pin_o <= pin_sel ? next_tff : 1'b0;
      shared_port_pin_o     <= pin_sel;
    end
  end

  a_ff_command: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && req.paddr == timer_pair_pkg::ADDR_FFCTL && req.pwdata[1:0] == 2'h1
    |=> toggle_flipflop) else $error("set command ignored");
  a_ff_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && req.paddr == timer_pair_pkg::ADDR_FFCTL && req.pwdata[1:0] == 2'h0
    |=> !toggle_flipflop) else $error("clear command ignored");
  a_ff_invert: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && req.paddr == timer_pair_pkg::ADDR_FFCTL && req.pwdata[1:0] == 2'h2
    |=> toggle_flipflop != $past(toggle_flipflop)) else $error("invert lost");
  a_cascade_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    match_irq_o[1] && $past(timer_mode_reg[1:0]) == timer_pair_pkg::MODE_16BIT
    |-> counter_low == 8'h00 && counter_high == 8'h00) else $error("cascade not cleared");
  a_arm_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && req.paddr == timer_pair_pkg::ADDR_CMP_LO |=> !arm16[0])
    else $error("compare not held off");
  a_toggle_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !ff_ctl[0] && !(wr && req.paddr == timer_pair_pkg::ADDR_FFCTL)
    |=> $stable(toggle_flipflop)) else $error("toggle while disabled");
  a_pwm_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    timer_mode_reg[1:0] == timer_pair_pkg::MODE_PWM
    |-> counter_high < pwm_top(timer_mode_reg[3:2])) else $error("pwm above top");
  a_pin_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pin_sel && $past(pin_sel) |-> flipflop_output_pin_o == toggle_flipflop)
    else $error("pin not tracking");
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench for the cascadable timer pair over apb
// Assumes: zero-wait apb slave, prescaler free running, pin select written first
// Notes:   tick length is measured, not assumed; periods checked as tick multiples
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic        err;
  } rd_exp_t;

  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  irq;
  logic        pin;
  logic        port_pin;
  rd_exp_t     exp_q[$];
  rd_exp_t     mon_e;
  int          error_cnt;
  int          checks;
  int          cycles;
  int          seed;
  int          tick;
  int          p0, p1, p2, p3, q, h, l, n, x, c, top, rv;
  logic [1:0]  ff_cmd [5] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h0};
  logic        ff_exp [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  timer_pair #(.CNT_W(8)) timer_pair_inst (
    .clk_i                 (clk),
    .resetn_i              (resetn),
    .psel_i                (psel),
    .penable_i             (penable),
    .pwrite_i              (pwrite),
    .paddr_i               (paddr),
    .pwdata_i              (pwdata),
    .prdata_o              (prdata),
    .pready_o              (pready),
    .pslverr_o             (pslverr),
    .match_irq_o           (irq),
    .flipflop_output_pin_o (pin),
    .shared_port_pin_o     (port_pin)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task summarize();
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ceiling well above the expected run of roughly 30k cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles >= 100000) begin
      error_cnt++;
      $display("MISMATCH at %0t: timeout", $time);
      summarize();
    end
  end

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: read got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask

  task chk_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: count got %0d exp %0d", $time, got, exp);
    end
  endtask

  // read results are taken at the completing access edge, oldest note first
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      chk_word(prdata & mon_e.mask, mon_e.data & mon_e.mask);
      chk_bit(pslverr, mon_e.err);
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
    exp_q.push_back('{data: d, mask: m, err: e});
    apb(1'b0, a, 32'h0);
  endtask

  task wait_irq(input int b, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (irq[b] !== 1'b1 && cnt < lim);
  endtask

  task period_irq(input int b, output int p);
    int d;
    wait_irq(b, 6000, d);
    wait_irq(b, 6000, p);
  endtask

  task wait_pin(input logic v, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (pin !== v && cnt < lim);
  endtask

  task pin_times(output int hi_t, output int lo_t);
    int d;
    wait_pin(1'b0, 6000, d);
    wait_pin(1'b1, 6000, d);
    wait_pin(1'b0, 6000, hi_t);
    wait_pin(1'b1, 6000, lo_t);
  endtask

  // both pairs cascaded alike; upper clock selects set to t256 to prove they are ignored
  task cfg16(input logic [7:0] lo, input logic [7:0] hi);
    wr(timer_pair_pkg::ADDR_RUN, 32'h0);
    wr(timer_pair_pkg::ADDR_MODE, 32'h11);
    wr(timer_pair_pkg::ADDR_CLKSEL, 32'hdd);
    wr(timer_pair_pkg::ADDR_CMP_LO, {24'h0, lo});
    wr(timer_pair_pkg::ADDR_CMP_HI, {24'h0, hi});
    wr(timer_pair_pkg::ADDR_CMP2_LO, {24'h0, lo});
    wr(timer_pair_pkg::ADDR_CMP2_HI, {24'h0, hi});
    wr(timer_pair_pkg::ADDR_RUN, 32'hf);
  endtask

  initial begin
    seed = 85;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    wr(timer_pair_pkg::ADDR_PIN, 32'h1);
    repeat (2) @(posedge clk);
    chk_bit(port_pin, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(timer_pair_pkg::ADDR_FFCTL, {30'h0, ff_cmd[i]});
      repeat (3) @(posedge clk);
      chk_bit(pin, ff_exp[i]);
    end
    rv = $random(seed);
    wr(timer_pair_pkg::ADDR_CLKSEL, rv);
    rd(timer_pair_pkg::ADDR_CLKSEL, {24'h0, rv[7:0]}, 32'hff, 1'b0);
    rd(8'h30, 32'h0, 32'hffffffff, 1'b1);
    wr(timer_pair_pkg::ADDR_FFCTL, 32'h0c);
    cfg16(8'h03, 8'h01);
    period_irq(1, p1);
    // lower is not cleared by its own match: two lower gaps make one 16-bit period
    period_irq(0, p0);
    wait_irq(0, 6000, x);
    chk_cnt(p0 + x, p1);
    period_irq(3, q);
    chk_cnt(q, p1);
    period_irq(2, q);
    wait_irq(2, 6000, x);
    chk_cnt(q + x, p1);
    pin_times(h, l);
    chk_cnt(h + l, 2 * p1);
    wait_irq(1, 6000, x);
    rd(timer_pair_pkg::ADDR_CNT, 32'h0, 32'hff000000, 1'b0);
    cfg16(8'h03, 8'h02);
    period_irq(1, p2);
    cfg16(8'h04, 8'h01);
    period_irq(1, p3);
    tick = p3 - p1;
    chk_cnt(p2 - p1, 256 * tick);
    // disarmed lower write: upper match must not come until the upper write
    wait_irq(1, 6000, x);
    wr(timer_pair_pkg::ADDR_CMP_LO, 32'h03);
    wait_irq(1, 3 * p1, n);
    chk_cnt(n, 3 * p1);
    wr(timer_pair_pkg::ADDR_RUN, 32'h0);
    wr(timer_pair_pkg::ADDR_CMP_HI, 32'h01);
    wr(timer_pair_pkg::ADDR_RUN, 32'hf);
    wait_irq(1, 3 * p1, n);
    chk_cnt(n < 3 * p1 ? 1 : 0, 1);
    // chained 8-bit: upper counts lower matches
    wr(timer_pair_pkg::ADDR_RUN, 32'h0);
    wr(timer_pair_pkg::ADDR_MODE, 32'h00);
    wr(timer_pair_pkg::ADDR_CLKSEL, 32'h01);
    wr(timer_pair_pkg::ADDR_CMP_HI, 32'h04);
    wr(timer_pair_pkg::ADDR_RUN, 32'h3);
    period_irq(1, p0);
    chk_cnt(p0, 12 * tick);
    for (int k = 0; k < 2; k++) begin
      wr(timer_pair_pkg::ADDR_RUN, 32'h0);
      wr(timer_pair_pkg::ADDR_MODE, 32'h02);
      wr(timer_pair_pkg::ADDR_CLKSEL, 32'h05);
      wr(timer_pair_pkg::ADDR_CMP_LO, 32'h05);
      wr(timer_pair_pkg::ADDR_CMP_HI, 32'h14);
      wr(timer_pair_pkg::ADDR_FFCTL, k == 0 ? 32'h0d : 32'h0c);
      wr(timer_pair_pkg::ADDR_RUN, 32'h3);
      pin_times(h, l);
      chk_cnt(h, (k == 0 ? 5 : 15) * tick);
      chk_cnt(l, (k == 0 ? 15 : 5) * tick);
    end
    // narrower width written in the lower match handler takes effect next period
    wait_irq(0, 6000, x);
    wr(timer_pair_pkg::ADDR_CMP_LO, 32'h03);
    pin_times(h, l);
    chk_cnt(l, 3 * tick);
    chk_cnt(h, 17 * tick);
    wr(timer_pair_pkg::ADDR_RUN, 32'h0);
    wr(timer_pair_pkg::ADDR_FFCTL, 32'h09);
    wr(timer_pair_pkg::ADDR_RUN, 32'h3);
    wait_pin(1'b0, 400, n);
    chk_cnt(n, 400);
    for (int s = 1; s < 4; s++) begin
      top = s == 1 ? int'(timer_pair_pkg::PWM_TOP6) :
            s == 2 ? int'(timer_pair_pkg::PWM_TOP7) : int'(timer_pair_pkg::PWM_TOP8);
      rv = $random(seed);
      c = 1 + ($unsigned(rv) % (top - 1));
      wr(timer_pair_pkg::ADDR_RUN, 32'h0);
      wr(timer_pair_pkg::ADDR_MODE, 32'h03 | (s << 2));
      wr(timer_pair_pkg::ADDR_CLKSEL, 32'h04);
      wr(timer_pair_pkg::ADDR_CMP_HI, c);
      wr(timer_pair_pkg::ADDR_FFCTL, 32'h0d);
      wr(timer_pair_pkg::ADDR_RUN, 32'h2);
      period_irq(1, p0);
      chk_cnt(p0, top * tick);
      pin_times(h, l);
      chk_cnt(h + l, top * tick);
      chk_cnt((h == c * tick || l == c * tick) ? 1 : 0, 1);
    end
    summarize();
  end
endmodule
